/* File: core/seq_pkg.sv */
// Purpose: Shared constants and types for the supply sequencer supervisor
// Assumes: Analog comparisons and timer expiries arrive as synchronous digital flags
// Notes:   Three-state pins are presented as two-bit codes
package seq_pkg;
  localparam int          NCH           = 4;
  localparam int          NPOS          = 8;
  localparam logic [3:0]  POS_FIRST     = 4'h1;
  localparam logic [3:0]  POS_LAST      = 4'h8;
  // Three-state pin codes
  localparam logic [1:0]  TRI_GND       = 2'h0;
  localparam logic [1:0]  TRI_OPEN      = 2'h1;
  localparam logic [1:0]  TRI_VCC       = 2'h2;
  // Threshold percentages handed to the analog side
  localparam logic [7:0]  OV_PCT_OPEN   = 8'h20;  // 32 %
  localparam logic [7:0]  OV_PCT_GND    = 8'h0c;  // 12 %
  localparam logic [7:0]  OV_PCT_VCC    = 8'h73;  // 115 %
  localparam logic [7:0]  SEQ_PCT_67    = 8'h43;  // 67 %
  localparam logic [7:0]  SEQ_PCT_DFLT  = 8'h64;  // 100 %
  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_FAULT    = 8'h08;
  localparam logic [7:0]  ADDR_OUTS     = 8'h0c;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int          CTRL_INHIBIT  = 0;
  localparam int          FLT_SEQ       = 0;
  localparam int          FLT_RST       = 1;
  localparam int          FLT_EXT       = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_UP_TICK, ST_UP_SEQ, ST_RELEASE, ST_MONITOR,
    ST_DN_TICK, ST_DN_SEQ, ST_FAULT
  } seq_state_t;
endpackage : seq_pkg

/* File: core/supply_sequencer_supervisor.sv */
// Purpose: Four-channel supply sequencer and supervisor with AXI4-Lite status
// Assumes: Inputs synchronous to clk_sys; timers are external and pulse on expiry
// Notes:   Open-drain pins appear as level plus output enable
`timescale 1ns/100ps
module supply_sequencer_supervisor (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Configuration pins
  input  wire logic [3*seq_pkg::NCH-1:0] position_select,
  input  wire logic [1:0]           threshold_ratio_select,
  input  wire logic [1:0]           excess_threshold_select,
  input  wire logic [1:0]           role_select_1,
  input  wire logic [1:0]           role_select_2,
  // Comparator flags
  input  wire logic                 on_above_start,
  input  wire logic                 on_above_stop,
  input  wire logic [seq_pkg::NCH-1:0] seq_above,
  input  wire logic [seq_pkg::NCH-1:0] uv_above,
  input  wire logic [seq_pkg::NCH-1:0] ov_above,
  // External timers
  output logic                      step_timer_run,
  input  wire logic                 step_timer_tick,
  output logic                      settle_timer_run,
  input  wire logic                 settle_timer_expire,
  output logic                      rst_delay_run,
  input  wire logic                 rst_delay_expire,
  output logic                      ov_delay_run,
  input  wire logic                 ov_delay_expire,
  // Supply and system pins
  output logic [seq_pkg::NCH-1:0]   supply_gate,
  output logic [seq_pkg::NCH-1:0]   monitor_good_out,
  output logic [7:0]                seq_threshold_pct,
  output logic [7:0]                ov_threshold_pct,
  output logic                      position_strobe_n,
  output logic                      reset_out_n,
  output logic                      excess_voltage_flag_n,
  input  wire logic                 fault_line_in,
  output logic                      fault_line_out,
  output logic                      fault_line_oe,
  input  wire logic                 done_in,
  output logic                      done_out,
  output logic                      done_oe,
  output logic                      hand_on
);
  import seq_pkg::*;

  seq_state_t       state_q, state_d;
  logic [3:0]       cur_q;
  logic [2:0]       pos_q [NCH];
  logic [NCH-1:0]   gates_q, good_q;
  logic             strobe_n_q, rst_n_q, ov_n_q, flt_q, done_low_q, last_q;
  logic             settle_q, step_q, rdly_q, odly_q, hand_q;
  logic [7:0]       seq_pct_q, ov_pct_q;
  logic [31:0]      ctrl_q;
  logic [2:0]       flog_q;
  logic [31:0]      rdata_q;
  logic [1:0]       bresp_q, rresp_q;
  logic             bvalid_q, rvalid_q;

  // Channel n pairs its monitor flags with its own position and gate
  logic [NCH-1:0]   used, match;
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    assign used[g]  = (pos_q[g] != 3'h0);
    assign match[g] = used[g] && ({1'b0, pos_q[g]} == cur_q - 4'h1);
  end

  wire all_uv      = &(uv_above | ~used);
  wire any_uv_drop = |(~uv_above & used);
  wire match_up    = &(seq_above | ~match);
  wire match_dn    = &(~seq_above | ~match);
  wire all_dn      = &(~seq_above | ~used);
  wire any_ov      = |ov_above;
  wire master_first = (role_select_1 == TRI_GND) && (role_select_2 == TRI_GND);
  wire inhibit     = ctrl_q[CTRL_INHIBIT];
  wire in_up       = (state_q == ST_UP_TICK) || (state_q == ST_UP_SEQ);
  wire in_dn       = (state_q == ST_DN_TICK) || (state_q == ST_DN_SEQ);
  wire powered     = in_up || (state_q == ST_RELEASE) || (state_q == ST_MONITOR);
  wire seq_fault   = settle_q && settle_timer_expire && (in_up || in_dn ||
                     state_q == ST_RELEASE);
  wire rst_fault   = (state_q == ST_MONITOR) && any_uv_drop && master_first;
  wire ext_fault   = !fault_line_in && !flt_q && (state_q != ST_FAULT);
  wire go_fault    = seq_fault || rst_fault || ext_fault;
  wire go_down     = powered && !on_above_stop;

  // Sequencer state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:    if (on_above_start && !inhibit) state_d = ST_UP_TICK;
      ST_UP_TICK: if (step_timer_tick) state_d = ST_UP_SEQ;
      ST_UP_SEQ:  if (match_up) state_d = (cur_q == POS_LAST) ? ST_RELEASE : ST_UP_TICK;
      ST_RELEASE: if (rdly_q && rst_delay_expire && all_uv) state_d = ST_MONITOR;
      ST_MONITOR: if (any_uv_drop) state_d = ST_RELEASE;
      ST_DN_TICK: if (step_timer_tick) state_d = ST_DN_SEQ;
      ST_DN_SEQ:  if (match_dn) state_d = (cur_q == POS_FIRST) ? ST_IDLE : ST_DN_TICK;
      ST_FAULT:   if (!on_above_stop && all_dn) state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
    if (go_down) state_d = ST_DN_TICK;
    if (go_fault) state_d = ST_FAULT;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cur_q   <= POS_FIRST;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) cur_q <= POS_FIRST;
      else if (state_q == ST_UP_SEQ && state_d == ST_UP_TICK) cur_q <= cur_q + 4'h1;
      else if (go_down) cur_q <= POS_LAST;
      else if (state_q == ST_DN_SEQ && state_d == ST_DN_TICK) cur_q <= cur_q - 4'h1;
    end
  end

  // Positions are latched once at the start so later pin changes cannot reorder
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NCH; i++) begin
      if (!reset_n) pos_q[i] <= 3'h0;
      else if (state_q == ST_IDLE && state_d == ST_UP_TICK)
        pos_q[i] <= position_select[3*i +: 3];
    end
  end

  // Gates and position strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gates_q    <= '0;
      strobe_n_q <= 1'b1;
      step_q     <= 1'b0;
    end else begin
      if (state_d == ST_FAULT) gates_q <= '0;
      else if (state_q == ST_UP_TICK && step_timer_tick) gates_q <= gates_q | match;
      else if (state_q == ST_DN_TICK && step_timer_tick && !go_down)
        gates_q <= gates_q & ~match;
      // Held low across the tick so each position shows one falling edge only
      strobe_n_q <= !(state_q == ST_UP_TICK || state_q == ST_DN_TICK) &&
                    !(state_q == ST_UP_SEQ && !match_up) &&
                    !(state_q == ST_DN_SEQ && !match_dn);
      step_q     <= (state_d == ST_UP_TICK) || (state_d == ST_DN_TICK);
    end
  end

  // Settle, reset and excess timers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      settle_q <= 1'b0;
      rdly_q   <= 1'b0;
      odly_q   <= 1'b0;
      rst_n_q  <= 1'b0;
      ov_n_q   <= 1'b1;
    end else begin
      if (state_d == ST_FAULT || state_d == ST_IDLE) settle_q <= 1'b0;
      else if (go_down) settle_q <= 1'b0;
      else if ((state_q == ST_UP_TICK || state_q == ST_DN_TICK) && step_timer_tick &&
               (match != '0) && !settle_q && (cur_q != 4'h0)) settle_q <= 1'b1;
      else if ((state_q == ST_RELEASE && all_uv) || (in_dn && all_dn)) settle_q <= 1'b0;
      rdly_q  <= (state_q == ST_RELEASE) && all_uv && !(rdly_q && rst_delay_expire);
      rst_n_q <= (state_d == ST_MONITOR);
      if (any_ov) ov_n_q <= 1'b0;
      else if (odly_q && ov_delay_expire) ov_n_q <= 1'b1;
      odly_q  <= !ov_n_q && !any_ov && !(odly_q && ov_delay_expire);
    end
  end

  // Fault line, done pin, monitor good and threshold selects
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flt_q      <= 1'b0;
      done_low_q <= 1'b0;
      last_q     <= 1'b1;
      good_q     <= '0;
      hand_q     <= 1'b0;
      seq_pct_q  <= SEQ_PCT_DFLT;
      ov_pct_q   <= OV_PCT_OPEN;
    end else begin
      flt_q <= (state_d == ST_FAULT) && (seq_fault || rst_fault || flt_q);
      if (state_q == ST_UP_SEQ && state_d == ST_RELEASE) done_low_q <= 1'b1;
      else if (state_q == ST_DN_SEQ && state_d == ST_IDLE) done_low_q <= 1'b0;
      if (!done_low_q) last_q <= done_in;
      hand_q <= !last_q && ((state_d == ST_RELEASE) || (state_d == ST_MONITOR));
      if (go_down || in_up || in_dn || state_q == ST_IDLE) good_q <= '0;
      else if (state_q == ST_RELEASE || state_q == ST_MONITOR || state_q == ST_FAULT)
        good_q <= uv_above & used;
      seq_pct_q <= (threshold_ratio_select == 2'h2) ? SEQ_PCT_67 : SEQ_PCT_DFLT;
      case (excess_threshold_select)
        TRI_GND: ov_pct_q <= OV_PCT_GND;
        TRI_VCC: ov_pct_q <= OV_PCT_VCC;
        default: ov_pct_q <= OV_PCT_OPEN;
      endcase
    end
  end

  assign supply_gate           = gates_q;
  assign monitor_good_out      = good_q;
  assign position_strobe_n     = strobe_n_q;
  assign reset_out_n           = rst_n_q;
  assign excess_voltage_flag_n = ov_n_q;
  assign fault_line_out        = 1'b0;
  assign fault_line_oe         = flt_q;
  assign done_out              = 1'b0;
  assign done_oe               = done_low_q;
  assign hand_on               = hand_q;
  assign step_timer_run        = step_q;
  assign settle_timer_run      = settle_q;
  assign rst_delay_run         = rdly_q;
  assign ov_delay_run          = odly_q;
  assign seq_threshold_pct     = seq_pct_q;
  assign ov_threshold_pct      = ov_pct_q;

  // AXI4-Lite slave: address and data are taken together, one write at a time
  wire wr_take  = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire rd_take  = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl  = wr_take && (s_axi_awaddr == ADDR_CTRL);
  wire wr_flt   = wr_take && (s_axi_awaddr == ADDR_FAULT);
  wire wr_ok    = (s_axi_awaddr == ADDR_CTRL) || (s_axi_awaddr == ADDR_FAULT);
  wire rd_ok    = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS) ||
                  (s_axi_araddr == ADDR_FAULT) || (s_axi_araddr == ADDR_OUTS);
  wire [2:0] flt_set = {ext_fault, rst_fault, seq_fault};
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL)   ? ctrl_q :
    (s_axi_araddr == ADDR_STATUS) ? {20'h0, last_q, rst_n_q, ov_n_q, flt_q,
                                     cur_q, 4'(state_q)} :
    (s_axi_araddr == ADDR_FAULT)  ? {29'h0, flog_q} :
    (s_axi_araddr == ADDR_OUTS)   ? {24'h0, good_q, gates_q} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_q   <= CTRL_RESET;
      flog_q   <= 3'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0;
    end else begin
      if (wr_ctrl && s_axi_wstrb[0]) ctrl_q[7:0] <= s_axi_wdata[7:0];
      // Write one to clear; a new fault in the same cycle stays logged
      flog_q <= ((wr_flt && s_axi_wstrb[0]) ? (flog_q & ~s_axi_wdata[2:0]) : flog_q)
                | flt_set;
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_q <= 1'b0;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  gates_off_a: assert property (state_q == ST_FAULT |-> gates_q == '0)
    else $error("gate on during fault");
  strobe_tick_a: assert property ((state_q == ST_UP_TICK) && $past(state_q == ST_UP_TICK)
    |-> !strobe_n_q)
    else $error("strobe not low in position");
  gate_space_a: assert property (
    (gates_q & ~$past(gates_q)) != '0 |-> $past(step_timer_tick))
    else $error("gate enabled without step tick");
  done_low_a: assert property (state_q == ST_MONITOR |-> done_oe)
    else $error("done not driven low after up");
  good_seq_a: assert property (state_q == ST_UP_SEQ |-> good_q == '0)
    else $error("monitor good high during sequencing");
  rst_mon_a: assert property ($rose(rst_n_q) |-> $past(rdly_q && rst_delay_expire && all_uv))
    else $error("reset released before delay expiry");
  rst_fault_a: assert property (rst_fault |=> state_q == ST_FAULT && fault_line_oe)
    else $error("reset fault not raised");
  restart_a: assert property (state_q == ST_FAULT && (on_above_stop || !all_dn) && !go_down
    |=> state_q == ST_FAULT)
    else $error("left fault early");
  down_a: assert property (state_q == ST_MONITOR && !on_above_stop && !go_fault
    |=> state_q == ST_DN_TICK && !reset_out_n && cur_q == POS_LAST ##1 good_q == '0)
    else $error("sequence down not started");
  ov_a: assert property (any_ov |=> !excess_voltage_flag_n)
    else $error("excess flag not low");
  settle_a: assert property (seq_fault |=> state_q == ST_FAULT)
    else $error("settle expiry missed");

  reach_mon_c: cover property (state_q == ST_RELEASE ##1 state_q == ST_MONITOR);
  down_end_c:  cover property (state_q == ST_DN_SEQ ##1 state_q == ST_IDLE);
  fault_c:     cover property (state_q == ST_MONITOR ##1 state_q == ST_FAULT);
endmodule : supply_sequencer_supervisor

/* File: testbench/supply_model.sv */
// Purpose: Far side: supplies that ramp with their gates, plus the external timers
// Assumes: One level step per ramp interval; comparator flags are clean and synchronous
// Notes:   Stuck, sag and ov_force inject only the faults the bench asks for
`timescale 1ns/100ps
module supply_model #(
  parameter int STEP   = 6,
  parameter int SETTLE = 300,
  parameter int DELAY  = 10
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Bench controls
  input  wire logic       slow,
  input  wire logic [3:0] stuck,
  input  wire logic [3:0] sag,
  input  wire logic       ov_force,
  // Device side
  input  wire logic [3:0] supply_gate,
  input  wire logic       step_timer_run,
  input  wire logic       settle_timer_run,
  input  wire logic       rst_delay_run,
  input  wire logic       ov_delay_run,
  output logic [3:0]      seq_above,
  output logic [3:0]      uv_above,
  output logic [3:0]      ov_above,
  output logic            step_timer_tick,
  output logic            settle_timer_expire,
  output logic            rst_delay_expire,
  output logic            ov_delay_expire
);
  localparam int LIM [4] = '{STEP, SETTLE, DELAY, DELAY};
  logic [2:0]  lvl_q [4];
  int          cnt_q [4];
  logic [31:0] age_q;
  logic [3:0]  run_w;
  assign run_w = {ov_delay_run, rst_delay_run, settle_timer_run, step_timer_run};
  always_ff @(posedge clk_sys) begin
    age_q <= reset_n ? age_q + 32'h1 : 32'h0;
    for (int i = 0; i < 4; i++) begin
      cnt_q[i] <= (!run_w[i] || cnt_q[i] == LIM[i] - 1) ? 0 : cnt_q[i] + 1;
      if (!reset_n) begin
        lvl_q[i] <= 3'h0;
      end else if (!slow || age_q[1:0] == 2'h0) begin
        // A stuck supply stalls above sequence level but short of undervoltage
        if (supply_gate[i] && lvl_q[i] != 3'h5 && !(stuck[i] && lvl_q[i] == 3'h3))
          lvl_q[i] <= lvl_q[i] + 3'h1;
        else if (!supply_gate[i] && lvl_q[i] != 3'h0)
          lvl_q[i] <= lvl_q[i] - 3'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      seq_above[i] = lvl_q[i] >= 3'h2;
      uv_above[i]  = lvl_q[i] >= 3'h4 && !sag[i];
    end
  end
  assign ov_above            = {3'h0, ov_force};
  assign step_timer_tick     = run_w[0] && cnt_q[0] == LIM[0] - 1;
  assign settle_timer_expire = run_w[1] && cnt_q[1] == LIM[1] - 1;
  assign rst_delay_expire    = run_w[2] && cnt_q[2] == LIM[2] - 1;
  assign ov_delay_expire     = run_w[3] && cnt_q[3] == LIM[3] - 1;
endmodule : supply_model

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the supply sequencer supervisor
// Assumes: Single device, first and last, master except in the closing role test; far side is supply_model
// Notes:   Positions come from a fixed-seed xorshift beside fixed corner cases
`timescale 1ns/100ps
module tb;
  import seq_pkg::*;
  localparam int STEP  = 6;
  localparam int DELAY = 10;
  logic        clk_sys = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, seq_threshold_pct, ov_threshold_pct;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h6543e8b5;
  logic [3:0]  s_axi_wstrb = 4'hf, stuck = 4'h0, sag = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, role_select_1 = TRI_GND, role_select_2 = TRI_GND;
  logic [11:0] position_select = 12'h0;
  logic [1:0]  threshold_ratio_select = 2'h0, excess_threshold_select = TRI_OPEN;
  logic        on_above_start = 1'b0, on_above_stop = 1'b0, slow = 1'b0, ov_force = 1'b0;
  logic [3:0]  seq_above, uv_above, ov_above, supply_gate, monitor_good_out;
  logic        step_timer_run, step_timer_tick, settle_timer_run, settle_timer_expire;
  logic        rst_delay_run, rst_delay_expire, ov_delay_run, ov_delay_expire, ov_tie = 1'b0;
  logic        position_strobe_n, reset_out_n, excess_voltage_flag_n, hand_on;
  logic        fault_line_in, fault_line_out, fault_line_oe, done_in, done_out, done_oe;
  int          failures = 0, checked = 0, rise [4], fall [4], pos [4];
  assign done_in       = ~done_oe;
  assign fault_line_in = ~fault_line_oe & (excess_voltage_flag_n | ~ov_tie);
  always #20 clk_sys = ~clk_sys;
  supply_sequencer_supervisor u_dut (.*);
  supply_model #(.STEP(STEP), .SETTLE(300), .DELAY(DELAY)) u_model (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [7:0] ov_pct(input logic [1:0] c);
    return c == TRI_GND ? OV_PCT_GND : (c == TRI_VCC ? OV_PCT_VCC : OV_PCT_OPEN);
  endfunction : ov_pct
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk_sys);
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic run_seq(input logic dn, input logic [11:0] ps);
    int         c, d, last, nstb;
    logic       prv;
    logic [3:0] used;
    last = 0;
    nstb = 0;
    prv = 1'b1;
    if (!dn) position_select <= ps;
    on_above_start <= !dn;
    on_above_stop <= !dn;
    for (int i = 0; i < 4; i++) begin
      if (!dn) pos[i] = ps[3*i +: 3];
      used[i] = pos[i] != 0;
      fall[i] = -1;
      if (!dn) rise[i] = -1;
    end
    for (c = 0; c < 3000 && (dn ? done_oe !== 1'b0 : reset_out_n !== 1'b1); c++) begin
      @(posedge clk_sys);
      if (prv === 1'b1 && position_strobe_n === 1'b0) nstb++;
      prv = position_strobe_n;
      if ((uv_above & used) !== used) last = c;
      if (dn && c == 4) chk("reset and good down", 0, {reset_out_n, monitor_good_out});
      if (!dn && done_oe !== 1'b1) chk("good in sequence", 0, monitor_good_out);
      for (int i = 0; i < 4; i++) begin
        if (dn && used[i] && supply_gate[i] === 1'b0 && fall[i] < 0) fall[i] = c;
        if (!dn && supply_gate[i] === 1'b1 && rise[i] < 0) begin
          rise[i] = c;
          for (int k = 0; k < 4; k++)
            if (used[k] && pos[k] < pos[i]) chk("earlier supply up", 1, seq_above[k]);
        end
      end
    end
    chk("strobe count", NPOS, nstb);
    chk("done level", !dn, done_oe);
    for (int i = 0; i < 4; i++) begin
      if (!used[i]) chk("masked gate", -1, rise[i]);
      for (int j = 0; j < 4; j++) begin
        d = dn ? fall[i] - fall[j] : rise[j] - rise[i];
        if (used[i] && used[j] && pos[i] <= pos[j])
          chk("gate order", 1, d >= (pos[j] - pos[i]) * STEP);
      end
    end
    if (!dn) begin
      chk("release delay", 1, c - last >= DELAY);
      axi_rd(ADDR_STATUS);
      chk("monitor state", 4, rd[3:0]);
      chk("good follows uv", uv_above & used, monitor_good_out);
      chk("cascade pins", 0, {done_out, fault_line_out, hand_on});
    end
    $display("test sequence dn=%0d done", dn);
  endtask : run_seq
  task automatic recover(input int b);
    on_above_start <= 1'b0;
    on_above_stop <= 1'b0;
    axi_rd(ADDR_FAULT);
    chk("fault log", 1, rd[b]);
    for (int c = 0; c < 200 && rd[3:0] !== 4'h0; c++) axi_rd(ADDR_STATUS);
    chk("back to idle", 0, rd[3:0]);
    axi_wr(ADDR_FAULT, 32'h7);
    axi_rd(ADDR_FAULT);
    chk("fault cleared", 0, rd[2:0]);
    $display("test fault %0d done", b);
  endtask : recover
  task automatic wrap_up();
    $display("counts checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    #(40 * 40000);
    failures++;
    wrap_up();
  end
  initial begin
    tick(8);
    reset_n <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      excess_threshold_select <= 2'(k);
      threshold_ratio_select <= 2'(k + 1);
      tick(3);
      chk("ov pct", ov_pct(2'(k)), ov_threshold_pct);
      chk("seq pct", k == 1 ? SEQ_PCT_67 : SEQ_PCT_DFLT, seq_threshold_pct);
    end
    axi_wr(ADDR_STATUS, 32'h0);
    chk("status write resp", RESP_SLVERR, rsp);
    axi_rd(8'h40);
    chk("unmapped resp", RESP_SLVERR, rsp);
    axi_wr(ADDR_CTRL, 32'h1);
    on_above_start <= 1'b1;
    on_above_stop <= 1'b1;
    tick(40);
    chk("inhibited gates", 0, supply_gate);
    on_above_start <= 1'b0;
    on_above_stop <= 1'b0;
    axi_wr(ADDR_CTRL, 32'h0);
    run_seq(1'b0, 12'h8ff);
    run_seq(1'b1, 12'h0);
    slow <= 1'b1;
    seed = xs(seed);
    run_seq(1'b0, seed[11:0]);
    sag <= 4'hf;
    tick(5);
    chk("reset on sag", 0, reset_out_n);
    chk("reset fault pulled", 1, fault_line_oe);
    chk("gates off", 0, supply_gate);
    sag <= 4'h0;
    tick(50);
    axi_rd(ADDR_STATUS);
    chk("restart blocked", 7, rd[3:0]);
    recover(FLT_RST);
    slow <= 1'b0;
    run_seq(1'b0, 12'h8c7);
    ov_tie <= 1'b1;
    ov_force <= 1'b1;
    tick(5);
    chk("ov flag", 0, excess_voltage_flag_n);
    chk("ov shutdown", 0, supply_gate);
    ov_force <= 1'b0;
    for (int c = 0; c < 200; c++) begin
      @(posedge clk_sys);
      if (excess_voltage_flag_n === 1'b1) begin
        chk("ov hold", 1, c >= DELAY - 2 && c < 3 * DELAY);
        break;
      end
    end
    ov_tie <= 1'b0;
    recover(FLT_EXT);
    stuck <= 4'h1;
    position_select <= 12'h8ff;
    on_above_start <= 1'b1;
    on_above_stop <= 1'b1;
    for (int c = 0; c < 2000 && fault_line_oe !== 1'b1; c++) @(posedge clk_sys);
    tick(3);
    chk("settle fault gates", 0, supply_gate);
    stuck <= 4'h0;
    recover(FLT_SEQ);
    role_select_1 <= TRI_OPEN;
    run_seq(1'b0, 12'h8ff);
    sag <= 4'h1;
    tick(5);
    chk("slave reset low", 0, reset_out_n);
    chk("slave no fault", 0, fault_line_oe);
    chk("slave gates held", 4'hf, supply_gate);
    $display("test role done");
    wrap_up();
  end
endmodule : tb
